/* inc/atm_oam_consts.svh */
// Offsets, field positions, reset values and timing constants of the VC OAM monitor.
// Included by the type package and by the design modules; definitions only.
`ifndef ATM_OAM_CONSTS_SVH
`define ATM_OAM_CONSTS_SVH
// Time base
`define CLK_MHZ 250
`define MS_PER_S 1000
`define MS_CYCLES_DFLT (`CLK_MHZ * 1000)
`define LB_INTERVAL_S 5
`define LOSS_TIME_DS 35
`define LOSS_TIME_MS (`LOSS_TIME_DS * 100)
`define FAR_HOLD_S 15
`define CC_ACT_WAIT_S 5
// Widths
`define CNT_W 32
`define RTT_W 16
`define LOSS_W 12
`define IRQ_W 5
`define AVG_SHIFT 3
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_CONFIG 8'h04
`define REG_STATUS 8'h08
`define REG_LB_BASE 8'h10
`define REG_LB_STRIDE 8'h20
`define LB_TX 8'h00
`define LB_RX 8'h04
`define LB_MIN 8'h08
`define LB_AVG 8'h0c
`define LB_MAX 8'h10
`define REG_CC_TX 8'h50
`define REG_CC_RX 8'h54
`define REG_IRQ_STATUS 8'h60
`define REG_IRQ_ENABLE 8'h64
`define REG_IRQ_CLEAR 8'h68
// Control bits (write one to act)
`define CTRL_E2E_START 0
`define CTRL_E2E_STOP 1
`define CTRL_SEG_START 2
`define CTRL_SEG_STOP 3
`define CTRL_CC_ACT 4
`define CTRL_CC_DEACT 5
// Config fields
`define CFG_DIR_LSB 0
`define CFG_AUTO_BIT 2
`define DIR_NONE 2'h0
`define DIR_RESET 2'h0
// Interrupt bits
`define IRQ_AIS 0
`define IRQ_RDI 1
`define IRQ_CC_OK 2
`define IRQ_CC_FAIL 3
`define IRQ_LB_RESP 4
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* inc/atm_oam_pkg.sv */
// Types of the VC OAM monitor: state enums and the packed state records.
// Count and RTT widths come from the constants header; tick, timer and AXI field widths are given here.
`include "atm_oam_consts.svh"
package atm_oam_pkg;
  typedef enum logic [1:0] {LB_INACTIVE, LB_ACTIVE, LB_LOOPBACK} lb_state_t;
  typedef enum logic [1:0] {CC_READY, CC_ACTIVE, CC_FAILED, CC_WAIT} cc_state_t;

  typedef struct packed {
    lb_state_t state;
    logic [`CNT_W-1:0] tx_cnt;
    logic [`CNT_W-1:0] rx_cnt;
    logic [`RTT_W-1:0] rtt_min;
    logic [`RTT_W-1:0] rtt_avg;
    logic [`RTT_W-1:0] rtt_max;
    logic rtt_seen;
    logic [`RTT_W-1:0] stamp;
    logic send;
    logic [2:0] sec_cnt;
    logic [3:0] far_s;
    logic tx_pulse;
  } lb_scope_t;

  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_state_t;

  typedef struct packed {
    logic [9:0] ms_cnt;
    logic [17:0] cyc_cnt;
    logic ms_tick;
    logic s_tick;
  } tick_state_t;
endpackage

/* core/oam_tick_gen.sv */
// Millisecond and one-second tick generator for the VC OAM monitor.
// Assumes one free-running clock; ticks are single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
`include "atm_oam_consts.svh"
module oam_tick_gen
  import atm_oam_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES_DFLT
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic ms_tick,
  output logic s_tick
);
  tick_state_t st;
  tick_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.ms_tick = 1'b0;
    next_st.s_tick = 1'b0;
    if (st.cyc_cnt == 18'(MS_CYCLES - 1)) begin
      next_st.cyc_cnt = '0;
      next_st.ms_tick = 1'b1;
      if (st.ms_cnt == 10'(`MS_PER_S - 1)) begin
        next_st.ms_cnt = '0;
        next_st.s_tick = 1'b1;
      end else begin
        next_st.ms_cnt = st.ms_cnt + 10'h001;
      end
    end else begin
      next_st.cyc_cnt = st.cyc_cnt + 18'h00001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ms_tick = st.ms_tick;
  assign s_tick = st.s_tick;
endmodule // oam_tick_gen
`default_nettype wire

/* core/atm_vc_oam_f5_monitor.sv */
// Per-VC OAM F5 monitor: loopback tests, continuity check, AIS and RDI state, AXI4-Lite registers.
// Assumes cell pulses are one cycle wide and synchronous to aclk.
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "atm_oam_consts.svh"
// Operation
// - Active local loopback sends one loopback cell every five seconds.
// - Loopback succeeds when returned cell count equals sent cell count.
// - End-to-end and segment loopbacks start and stop independently by command.
// - State shows Active when local, Loopback when far-initiated, else Inactive.
// - Per VC, separate counts of loopback cells sent and received.
// - Round-trip delay measured in ms; minimum, average and maximum kept.
// - Statistics clear when state leaves Inactive for Active or Loopback.
// - Statistics update only in Active state on a response cell.
// - Far-initiated loopback leaves statistics at zero.
// - Activating endpoint picks sink, source or both directions.
// - Check state reads Ready, Active, or Activation Failed; also reads Wait while activation is pending.
// - Bidirectional check sends and expects one check cell per second.
// - Sink with no cell for 3.5 s sets AIS, sends AIS each second.
// - Auto start launches the check on operational Down to Up.
// - AIS indication set while AIS cells arrive.
// - Without active check, AIS clears after 3.5 s without AIS cells.
// - With active check, AIS clears on a check or user cell.
// - RDI set while RDI cells arrive, clears after 3.5 s without.
module atm_vc_oam_f5_monitor
  import atm_oam_pkg::*;
#(
  parameter int MS_CYCLES = `MS_CYCLES_DFLT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic oper_up,
  input wire logic [1:0] rx_lb_resp,
  input wire logic [1:0] rx_lb_far,
  input wire logic rx_cc_cell,
  input wire logic rx_user_cell,
  input wire logic rx_ais_cell,
  input wire logic rx_rdi_cell,
  input wire logic cc_act_ack,
  input wire logic cc_act_ok,
  output logic [1:0] tx_lb_cell,
  output logic tx_cc_cell,
  output logic tx_ais_cell,
  output logic cc_act_req,
  output logic cc_deact_req,
  output logic [1:0] check_direction_out,
  output logic irq
);
  typedef struct packed {
    axi_state_t axi;
    lb_scope_t [1:0] lb;
    cc_state_t cc;
    logic [1:0] check_direction;
    logic check_auto_start;
    logic [2:0] cc_wait_s;
    logic [`CNT_W-1:0] cc_tx_cnt;
    logic [`CNT_W-1:0] cc_rx_cnt;
    logic [`LOSS_W-1:0] sink_ms;
    logic ais;
    logic ais_local;
    logic [`LOSS_W-1:0] ais_ms;
    logic rdi;
    logic [`LOSS_W-1:0] rdi_ms;
    logic oper_up_q;
    logic [`RTT_W-1:0] ms_now;
    logic cc_req;
    logic cc_stop;
    logic cc_tx;
    logic ais_tx;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_enable;
  } state_t;

  state_t st;
  state_t next_st;
  logic ms_tick;
  logic s_tick;

  oam_tick_gen #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ms_tick(ms_tick),
    .s_tick(s_tick)
  );

  function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a, output logic hit);
    logic [7:0] off;
    read_reg = '0;
    hit = 1'b1;
    off = 8'h00;
    case (a)
      `REG_CTRL, `REG_IRQ_CLEAR: read_reg = '0;
      `REG_CONFIG: read_reg = {29'h0, s.check_auto_start, s.check_direction};
      `REG_STATUS: begin
        read_reg = {22'h0,
                    (s.lb[1].state == LB_ACTIVE) && (s.lb[1].tx_cnt != '0) && (s.lb[1].rx_cnt == s.lb[1].tx_cnt),
                    (s.lb[0].state == LB_ACTIVE) && (s.lb[0].tx_cnt != '0) && (s.lb[0].rx_cnt == s.lb[0].tx_cnt),
                    s.rdi, s.ais, s.cc, s.lb[1].state, s.lb[0].state};
      end
      `REG_CC_TX: read_reg = s.cc_tx_cnt;
      `REG_CC_RX: read_reg = s.cc_rx_cnt;
      `REG_IRQ_STATUS: read_reg = {27'h0, s.irq_status};
      `REG_IRQ_ENABLE: read_reg = {27'h0, s.irq_enable};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < 2; i++) begin
          off = a - (`REG_LB_BASE + 8'(i) * `REG_LB_STRIDE);
          if (a >= `REG_LB_BASE + 8'(i) * `REG_LB_STRIDE && off <= `LB_MAX && off[1:0] == 2'h0) begin
            hit = 1'b1;
            case (off)
              `LB_TX: read_reg = s.lb[i].tx_cnt;
              `LB_RX: read_reg = s.lb[i].rx_cnt;
              `LB_MIN: read_reg = {16'h0, s.lb[i].rtt_min};
              `LB_AVG: read_reg = {16'h0, s.lb[i].rtt_avg};
              default: read_reg = {16'h0, s.lb[i].rtt_max};
            endcase
          end
        end
      end
    endcase
  endfunction

  always_comb begin
    logic [5:0] cmd;
    logic [`IRQ_W-1:0] clr;
    logic [`IRQ_W-1:0] ev;
    logic [`RTT_W-1:0] rtt;
    logic [`RTT_W+`AVG_SHIFT-1:0] avg_sum;
    logic hit;
    logic act;
    logic cc_on;
    cmd = '0;
    clr = '0;
    ev = '0;
    rtt = '0;
    avg_sum = '0;
    hit = 1'b0;
    act = 1'b0;
    cc_on = 1'b0;
    next_st = st;
    next_st.cc_req = 1'b0;
    next_st.cc_stop = 1'b0;
    next_st.cc_tx = 1'b0;
    next_st.ais_tx = 1'b0;
    next_st.oper_up_q = oper_up;
    if (ms_tick) begin
      next_st.ms_now = st.ms_now + 16'h0001;
    end

    // AXI write path
    if (!st.axi.aw_full && s_axi_awvalid) begin
      next_st.axi.aw_full = 1'b1;
      next_st.axi.aw_addr = s_axi_awaddr;
    end
    if (!st.axi.w_full && s_axi_wvalid) begin
      next_st.axi.w_full = 1'b1;
      next_st.axi.w_data = s_axi_wdata;
      next_st.axi.w_strb = s_axi_wstrb;
    end
    if (st.axi.bvalid && s_axi_bready) begin
      next_st.axi.bvalid = 1'b0;
    end
    if (st.axi.aw_full && st.axi.w_full && !st.axi.bvalid) begin
      next_st.axi.aw_full = 1'b0;
      next_st.axi.w_full = 1'b0;
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp = `RESP_OKAY;
      void'(read_reg(st, st.axi.aw_addr, hit));
      if (!hit) begin
        next_st.axi.bresp = `RESP_SLVERR;
      end else if (st.axi.w_strb[0]) begin
        case (st.axi.aw_addr)
          `REG_CTRL: cmd = st.axi.w_data[5:0];
          `REG_CONFIG: begin
            next_st.check_direction = st.axi.w_data[`CFG_DIR_LSB+:2];
            next_st.check_auto_start = st.axi.w_data[`CFG_AUTO_BIT];
          end
          `REG_IRQ_ENABLE: next_st.irq_enable = st.axi.w_data[`IRQ_W-1:0];
          `REG_IRQ_CLEAR: clr = st.axi.w_data[`IRQ_W-1:0];
          default: ;
        endcase
      end
    end

    // AXI read path
    if (st.axi.rvalid && s_axi_rready) begin
      next_st.axi.rvalid = 1'b0;
    end
    if (!st.axi.rvalid && s_axi_arvalid) begin
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rdata = read_reg(st, s_axi_araddr, hit);
      next_st.axi.rresp = hit ? `RESP_OKAY : `RESP_SLVERR;
    end

    // Loopback scopes
    for (int i = 0; i < 2; i++) begin
      next_st.lb[i].tx_pulse = 1'b0;
      unique case (st.lb[i].state)
        LB_INACTIVE: begin
          if (cmd[2*i]) begin
            next_st.lb[i].state = LB_ACTIVE;
            next_st.lb[i].rtt_min = '0;
            next_st.lb[i].rtt_avg = '0;
            next_st.lb[i].rtt_max = '0;
            next_st.lb[i].rtt_seen = 1'b0;
            next_st.lb[i].tx_cnt = '0;
            next_st.lb[i].rx_cnt = '0;
            next_st.lb[i].send = 1'b1;
            next_st.lb[i].sec_cnt = '0;
          end else if (rx_lb_far[i]) begin
            next_st.lb[i].state = LB_LOOPBACK;
            next_st.lb[i].rtt_min = '0;
            next_st.lb[i].rtt_avg = '0;
            next_st.lb[i].rtt_max = '0;
            next_st.lb[i].rtt_seen = 1'b0;
            next_st.lb[i].far_s = '0;
            next_st.lb[i].rx_cnt = st.lb[i].rx_cnt + 32'h1;
          end
        end
        LB_ACTIVE: begin
          if (cmd[2*i+1]) begin
            next_st.lb[i].state = LB_INACTIVE;
            next_st.lb[i].send = 1'b0;
          end else begin
            if (s_tick) begin
              if (st.lb[i].sec_cnt == 3'(`LB_INTERVAL_S - 1)) begin
                next_st.lb[i].sec_cnt = '0;
                next_st.lb[i].send = 1'b1;
              end else begin
                next_st.lb[i].sec_cnt = st.lb[i].sec_cnt + 3'h1;
              end
            end
            if (st.lb[i].send) begin
              next_st.lb[i].send = 1'b0;
              next_st.lb[i].tx_pulse = 1'b1;
              next_st.lb[i].tx_cnt = st.lb[i].tx_cnt + 32'h1;
              next_st.lb[i].stamp = st.ms_now;
            end
            if (rx_lb_resp[i] || rx_lb_far[i]) begin
              next_st.lb[i].rx_cnt = st.lb[i].rx_cnt + 32'h1;
            end
            if (rx_lb_resp[i]) begin
              ev[`IRQ_LB_RESP] = 1'b1;
              rtt = st.ms_now - st.lb[i].stamp;
              avg_sum = ({3'h0, st.lb[i].rtt_avg} << `AVG_SHIFT) - {3'h0, st.lb[i].rtt_avg} + {3'h0, rtt};
              next_st.lb[i].rtt_seen = 1'b1;
              if (!st.lb[i].rtt_seen) begin
                next_st.lb[i].rtt_min = rtt;
                next_st.lb[i].rtt_max = rtt;
                next_st.lb[i].rtt_avg = rtt;
              end else begin
                if (rtt < st.lb[i].rtt_min) next_st.lb[i].rtt_min = rtt;
                if (rtt > st.lb[i].rtt_max) next_st.lb[i].rtt_max = rtt;
                next_st.lb[i].rtt_avg = avg_sum[`RTT_W+`AVG_SHIFT-1:`AVG_SHIFT];
              end
            end
          end
        end
        LB_LOOPBACK: begin
          if (cmd[2*i]) begin
            next_st.lb[i].state = LB_ACTIVE;
            next_st.lb[i].tx_cnt = '0;
            next_st.lb[i].rx_cnt = '0;
            next_st.lb[i].send = 1'b1;
            next_st.lb[i].sec_cnt = '0;
          end else if (rx_lb_far[i]) begin
            next_st.lb[i].far_s = '0;
            next_st.lb[i].rx_cnt = st.lb[i].rx_cnt + 32'h1;
          end else if (cmd[2*i+1] || (s_tick && st.lb[i].far_s == 4'(`FAR_HOLD_S - 1))) begin
            next_st.lb[i].state = LB_INACTIVE;
          end else if (s_tick) begin
            next_st.lb[i].far_s = st.lb[i].far_s + 4'h1;
          end
        end
      endcase
    end

    // Continuity check activation
    act = cmd[`CTRL_CC_ACT] || (st.check_auto_start && st.check_direction != `DIR_NONE && oper_up && !st.oper_up_q);
    if (cmd[`CTRL_CC_DEACT]) begin
      next_st.cc = CC_READY;
      next_st.cc_stop = 1'b1;
    end else if (act && st.cc != CC_WAIT) begin
      if (st.check_direction == `DIR_NONE) begin
        next_st.cc = CC_FAILED;
        ev[`IRQ_CC_FAIL] = 1'b1;
      end else begin
        next_st.cc = CC_WAIT;
        next_st.cc_req = 1'b1;
        next_st.cc_wait_s = '0;
        next_st.cc_tx_cnt = '0;
        next_st.cc_rx_cnt = '0;
        next_st.sink_ms = '0;
      end
    end else if (st.cc == CC_WAIT) begin
      if (cc_act_ack) begin
        next_st.cc = cc_act_ok ? CC_ACTIVE : CC_FAILED;
        ev[`IRQ_CC_OK] = cc_act_ok;
        ev[`IRQ_CC_FAIL] = !cc_act_ok;
      end else if (s_tick) begin
        if (st.cc_wait_s == 3'(`CC_ACT_WAIT_S - 1)) begin
          next_st.cc = CC_FAILED;
          ev[`IRQ_CC_FAIL] = 1'b1;
        end else begin
          next_st.cc_wait_s = st.cc_wait_s + 3'h1;
        end
      end
    end

    // Source, sink and AIS
    cc_on = (st.cc == CC_ACTIVE);
    if (cc_on && rx_cc_cell) begin
      next_st.cc_rx_cnt = st.cc_rx_cnt + 32'h1;
    end
    if (cc_on && st.check_direction[1] && s_tick) begin
      next_st.cc_tx = 1'b1;
      next_st.cc_tx_cnt = st.cc_tx_cnt + 32'h1;
    end
    if (rx_ais_cell) begin
      next_st.ais_ms = '0;
    end else if (ms_tick && st.ais_ms != `LOSS_W'(`LOSS_TIME_MS)) begin
      next_st.ais_ms = st.ais_ms + 12'h001;
    end
    if (cc_on && (rx_cc_cell || rx_user_cell)) begin
      next_st.ais = 1'b0;
      next_st.ais_local = 1'b0;
    end else if (!cc_on && st.ais_ms == `LOSS_W'(`LOSS_TIME_MS)) begin
      next_st.ais = 1'b0;
      next_st.ais_local = 1'b0;
    end
    if (!cc_on || !st.check_direction[0] || rx_cc_cell || rx_user_cell) begin
      next_st.sink_ms = '0;
    end else if (ms_tick && st.sink_ms != `LOSS_W'(`LOSS_TIME_MS)) begin
      next_st.sink_ms = st.sink_ms + 12'h001;
      if (st.sink_ms == `LOSS_W'(`LOSS_TIME_MS - 1)) begin
        next_st.ais = 1'b1;
        next_st.ais_local = 1'b1;
      end
    end
    if (rx_ais_cell) begin
      next_st.ais = 1'b1;
    end
    if (st.ais_local && s_tick) begin
      next_st.ais_tx = 1'b1;
    end
    ev[`IRQ_AIS] = next_st.ais && !st.ais;

    // RDI
    if (rx_rdi_cell) begin
      next_st.rdi = 1'b1;
      next_st.rdi_ms = '0;
    end else if (ms_tick && st.rdi) begin
      if (st.rdi_ms == `LOSS_W'(`LOSS_TIME_MS - 1)) begin
        next_st.rdi = 1'b0;
      end
      next_st.rdi_ms = st.rdi_ms + 12'h001;
    end
    ev[`IRQ_RDI] = rx_rdi_cell && !st.rdi;

    // Sticky interrupt status, set wins over clear
    next_st.irq_status = (st.irq_status & ~clr) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = !st.axi.aw_full;
  assign s_axi_wready = !st.axi.w_full;
  assign s_axi_bvalid = st.axi.bvalid;
  assign s_axi_bresp = st.axi.bresp;
  assign s_axi_arready = !st.axi.rvalid;
  assign s_axi_rvalid = st.axi.rvalid;
  assign s_axi_rdata = st.axi.rdata;
  assign s_axi_rresp = st.axi.rresp;
  assign tx_lb_cell = {st.lb[1].tx_pulse, st.lb[0].tx_pulse};
  assign tx_cc_cell = st.cc_tx;
  assign tx_ais_cell = st.ais_tx;
  assign cc_act_req = st.cc_req;
  assign cc_deact_req = st.cc_stop;
  assign check_direction_out = st.check_direction;
  assign irq = |(st.irq_status & st.irq_enable);
endmodule // atm_vc_oam_f5_monitor
`default_nettype wire

/* verif/oam_port_monitor.sv */
// Concurrent checks on the ports of the VC OAM monitor.
// Bound into the monitor module; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module oam_port_checker #(
  parameter int MS_CYCLES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] tx_lb_cell,
  input wire logic tx_cc_cell,
  input wire logic tx_ais_cell,
  input wire logic cc_act_req
);
  localparam int ONE_S = 1000 * MS_CYCLES;
  logic [31:0] lb_gap;
  logic lb_seen;
  // Cycles since the last end-to-end loopback cell
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lb_gap <= 32'h0;
      lb_seen <= 1'b0;
    end else if (tx_lb_cell[0]) begin
      lb_gap <= 32'h0;
      lb_seen <= 1'b1;
    end else begin
      lb_gap <= lb_gap + 32'h1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read data pending");
  a_lb_interval: assert property (tx_lb_cell[0] && lb_seen |-> lb_gap >= 4 * ONE_S - 2 && lb_gap <= 5 * ONE_S)
    else $error("loopback cell spacing wrong");
  a_lb_pulse: assert property (tx_lb_cell[0] |=> !tx_lb_cell[0])
    else $error("loopback cell pulse too long");
  a_cc_tx_gap: assert property (tx_cc_cell |=> !tx_cc_cell [*8])
    else $error("check cells too close");
  a_ais_tx_gap: assert property (tx_ais_cell |=> !tx_ais_cell [*8])
    else $error("alarm cells too close");
  a_req_single: assert property (cc_act_req |=> !cc_act_req)
    else $error("activation request repeated");
endmodule // oam_port_checker
`default_nettype wire

/* verif/oam_far_end.sv */
// Far ATM endpoint model: returns our loopback cells and answers activation.
// Assumes one-cycle request pulses from the monitor on the same clock.
`timescale 1ns/1ps
`default_nettype none
module oam_far_end #(
  parameter int RTT_CYC = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] tx_lb_cell,
  input wire logic cc_act_req,
  input wire logic accept,
  output logic [1:0] rx_lb_resp,
  output logic cc_act_ack,
  output logic cc_act_ok
);
  int lb_wait [2];
  int ack_wait;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_lb_resp <= 2'b00;
      cc_act_ack <= 1'b0;
      cc_act_ok <= 1'b0;
      ack_wait <= 0;
      lb_wait <= '{0, 0};
    end else begin
      // Answer level is meaningless off the ack, so it toggles
      cc_act_ack <= (ack_wait == 1);
      cc_act_ok <= (ack_wait == 1) ? accept : ~cc_act_ok;
      ack_wait <= cc_act_req ? 8 : (ack_wait > 0 ? ack_wait - 1 : 0);
      for (int i = 0; i < 2; i++) begin
        lb_wait[i] <= tx_lb_cell[i] ? RTT_CYC : (lb_wait[i] > 0 ? lb_wait[i] - 1 : 0);
        rx_lb_resp[i] <= (lb_wait[i] == 1);
      end
    end
  end
endmodule // oam_far_end
`default_nettype wire

/* verif/tb_top.sv */
// Bench for the VC OAM monitor: register table, loopback, alarms, continuity check.
// Uses a shortened millisecond; the far endpoint is a separate model.
`timescale 1ns/1ps
`default_nettype none
`include "atm_oam_consts.svh"
module tb_top;
  localparam int MS = 2;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] rs;} row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic oper_up = 1'b0;
  logic [1:0] rx_lb_far = 2'b00;
  logic rx_cc_cell = 1'b0;
  logic rx_user_cell = 1'b0;
  logic rx_ais_cell = 1'b0;
  logic rx_rdi_cell = 1'b0;
  logic accept = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rx_lb_resp, tx_lb_cell, check_direction_out;
  logic [31:0] s_axi_rdata, v, m;
  logic cc_act_ack, cc_act_ok, tx_cc_cell, tx_ais_cell, cc_act_req, cc_deact_req, irq;
  logic [1:0] r;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  row_t rows [8] = '{
    '{1'b0, `REG_CONFIG, 32'h0, 32'h0, `RESP_OKAY},
    '{1'b0, `REG_STATUS, 32'h0, 32'h0, `RESP_OKAY},
    '{1'b0, `REG_CTRL, 32'h0, 32'h0, `RESP_OKAY},
    '{1'b0, 8'h24, 32'h0, 32'h0, `RESP_SLVERR},
    '{1'b1, 8'h2c, 32'h5, 32'h0, `RESP_SLVERR},
    '{1'b1, `REG_IRQ_ENABLE, 32'h1f, 32'h0, `RESP_OKAY},
    '{1'b0, `REG_IRQ_ENABLE, 32'h0, 32'h1f, `RESP_OKAY},
    '{1'b0, `REG_LB_BASE, 32'h0, 32'h0, `RESP_OKAY}};

  atm_vc_oam_f5_monitor #(.MS_CYCLES(MS)) u_atm_vc_oam_f5_monitor (.*);
  oam_far_end #(.RTT_CYC(20 * MS)) u_oam_far_end (.*);

  initial forever #2 aclk = ~aclk;

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc > 60000) begin
      errors++;
      stop_test();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_ms(int k);
    repeat (k * MS) @(posedge aclk);
  endtask

  task automatic wait_tx(int which, int limit, output int cnt);
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (!(which == 0 ? tx_lb_cell[0] : which == 1 ? tx_cc_cell : tx_ais_cell) && cnt < limit);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_wr(rows[i].a, rows[i].d, r);
      end else begin
        axi_rd(rows[i].a, v, r);
        check("rdata", v, rows[i].x);
      end
      check("resp", 32'(r), 32'(rows[i].rs));
    end
    axi_wr(`REG_CTRL, 32'h1, r);
    axi_rd(`REG_STATUS, v, r);
    check("e2e active", v & 32'hf, 32'h1);
    wait_ms(30);
    axi_rd(`REG_LB_BASE + `LB_MIN, m, r);
    check("rtt min", 32'(m >= 19 && m <= 21), 32'h1);
    axi_rd(`REG_LB_BASE + `LB_AVG, v, r);
    check("rtt avg", v, m);
    axi_rd(`REG_LB_BASE + `LB_MAX, v, r);
    check("rtt max", v, m);
    axi_rd(`REG_STATUS, v, r);
    check("lb success", v & 32'h100, 32'h100);
    check("irq on", 32'(irq), 32'h1);
    wait_tx(0, 5000 * MS + 20, n);
    check("lb spacing", 32'(n >= 3900 * MS && n <= 5000 * MS), 32'h1);
    wait_ms(30);
    axi_rd(`REG_LB_BASE + `LB_TX, v, r);
    check("lb tx", v, 32'h2);
    axi_rd(`REG_LB_BASE + `LB_RX, v, r);
    check("lb rx", v, 32'h2);
    axi_wr(`REG_CTRL, 32'h2, r);
    axi_wr(`REG_IRQ_CLEAR, 32'h1f, r);
    check("irq cleared", 32'(irq), 32'h0);
    @(posedge aclk);
    rx_lb_far <= 2'b10;
    @(posedge aclk);
    rx_lb_far <= 2'b00;
    axi_rd(`REG_STATUS, v, r);
    check("seg far", v & 32'hf, 32'h8);
    axi_rd(`REG_LB_BASE + `REG_LB_STRIDE + `LB_MIN, v, r);
    check("far rtt", v, 32'h0);
    axi_wr(`REG_CTRL, 32'h4, r);
    axi_rd(`REG_STATUS, v, r);
    check("seg start", v & 32'hc, 32'h4);
    axi_wr(`REG_CTRL, 32'h8, r);
    axi_wr(`REG_IRQ_ENABLE, 32'h0, r);
    @(posedge aclk);
    rx_ais_cell <= 1'b1;
    rx_rdi_cell <= 1'b1;
    @(posedge aclk);
    rx_ais_cell <= 1'b0;
    rx_rdi_cell <= 1'b0;
    wait_ms(3000);
    axi_rd(`REG_STATUS, v, r);
    check("alarms set", v & 32'hcc, 32'hc0);
    check("irq masked", 32'(irq), 32'h0);
    axi_rd(`REG_IRQ_STATUS, v, r);
    check("irq status", v & 32'h3, 32'h3);
    wait_ms(600);
    axi_rd(`REG_STATUS, v, r);
    check("alarms clear", v & 32'hc0, 32'h0);
    axi_wr(`REG_IRQ_ENABLE, 32'h3, r);
    check("irq enabled", 32'(irq), 32'h1);
    axi_wr(`REG_IRQ_CLEAR, 32'h3, r);
    check("irq clear", 32'(irq), 32'h0);
    axi_wr(`REG_CONFIG, 32'h7, r);
    oper_up <= 1'b1;
    wait_ms(15);
    axi_rd(`REG_STATUS, v, r);
    check("auto start", v & 32'h30, 32'h10);
    check("direction", 32'(check_direction_out), 32'h3);
    @(posedge aclk);
    rx_ais_cell <= 1'b1;
    @(posedge aclk);
    rx_ais_cell <= 1'b0;
    axi_rd(`REG_STATUS, v, r);
    check("ais on", v & 32'h40, 32'h40);
    @(posedge aclk);
    rx_cc_cell <= 1'b1;
    @(posedge aclk);
    rx_cc_cell <= 1'b0;
    axi_rd(`REG_STATUS, v, r);
    check("ais off", v & 32'h40, 32'h0);
    wait_tx(1, 1000 * MS + 20, n);
    check("cc source", 32'(n <= 1000 * MS), 32'h1);
    wait_ms(3600);
    axi_rd(`REG_STATUS, v, r);
    check("sink loss", v & 32'h40, 32'h40);
    wait_tx(2, 1000 * MS + 20, n);
    check("ais cell", 32'(n <= 1000 * MS), 32'h1);
    axi_wr(`REG_CTRL, 32'h20, r);
    check("deact req", 32'(cc_deact_req), 32'h1);
    accept <= 1'b0;
    axi_rd(`REG_STATUS, v, r);
    check("cc ready", v & 32'h30, 32'h0);
    axi_wr(`REG_CTRL, 32'h10, r);
    wait_ms(15);
    axi_rd(`REG_STATUS, v, r);
    check("cc failed", v & 32'h30, 32'h20);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`REG_STATUS, v, r);
    check("reset", v, 32'h0);
    stop_test();
  end
endmodule // tb_top
bind atm_vc_oam_f5_monitor oam_port_checker #(.MS_CYCLES(MS_CYCLES)) u_oam_port_checker (.*);
`default_nettype wire
